//--- src/ccg_pkg.sv
// Package of constants and types shared by the clock generation unit.
package ccg_pkg;

   // ==========================================================
   // Special function register addresses
   localparam logic [7:0] ADDR_TRIM = 8'h96;
   localparam logic [7:0] ADDR_DIV = 8'hc8;
   localparam logic [7:0] ADDR_AUX1 = 8'hc9;

   // ==========================================================
   // Field positions and widths
   localparam int TRIM_W = 6;
   localparam int TRIM_RCSEL_BIT = 7;
   localparam int TRIM_SPARE_BIT = 6;
   localparam int AUX1_LP_BIT = 7;
   localparam int DIV_REG_W = 8;

   // ==========================================================
   // Values after reset
   localparam logic [7:0] DIV_RST = 8'h00;
   localparam logic AUX1_LP_RST = 1'b0;
   localparam logic TRIM_RCSEL_RST = 1'b0;
   localparam logic TRIM_SPARE_RST = 1'b0;

   // ==========================================================
   // Frequencies in kHz, as nominal figures
   localparam int RC_FREQ_KHZ = 7373;
   localparam int RC_DBL_FREQ_KHZ = 14746;
   localparam int WDT_FREQ_KHZ = 400;
   localparam int EXT_MAX_KHZ = 18000;
   localparam int LOW_POWER_MAX_KHZ = 8000;
   localparam int CORE_CLK_KHZ = 20000;

   // ==========================================================
   // Wake-up hold counts, in edges of the selected source
   localparam int WAKE_RC_EDGES = 256;
   localparam int WAKE_WDT_EDGES = 32;
   localparam int WAKE_EXT_EDGES = 32;
   localparam int WAKE_CNT_W = 12;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      SRC_RC = 2'h0,
      SRC_WDT = 2'h1,
      SRC_EXT = 2'h2
   } ccg_src_t;

   typedef enum logic {
      ST_WAIT = 1'b0,
      ST_RUN = 1'b1
   } ccg_state_t;

   typedef struct packed {
      logic rc_doubler;
      ccg_src_t src;
   } ccg_ucfg_t;

   typedef struct packed {
      logic cpu;
      logic machine;
      logic periph;
   } ccg_ticks_t;

endpackage

//--- src/ccg_divider.sv
// Programmable divider turning source edges into CPU, machine and peripheral ticks.
`timescale 1ns/1ps
module ccg_divider #(
   parameter int DIV_W = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Source and control
   input wire logic src_tick,
   input wire logic run,
   input wire logic [DIV_W-1:0] div_value,
   // Tick outputs
   output ccg_pkg::ccg_ticks_t ticks
);

   // ==========================================================
   // Period counter
   logic [DIV_W:0] cnt_ff;
   logic [DIV_W-1:0] div_ff;
   logic phase_ff;
   ccg_pkg::ccg_ticks_t ticks_ff;
   logic [DIV_W:0] last;
   logic period_end;

   // Zero passes the source through; N gives one CPU period per 2N source edges.
   always_comb begin
      if (div_ff == '0) begin
         last = '0;
      end else begin
         last = {div_ff, 1'b0} - (DIV_W+1)'(1);
      end
   end

   assign period_end = run && src_tick && (cnt_ff == last);

   // A new divider value is taken only at the end of a whole CPU period or while the divider is stopped, so
   // software may write it at any time without a shortened pulse.
   always_ff @(posedge clk) begin
      if (rst || !run) begin
         cnt_ff <= '0;
         div_ff <= div_value;
      end else if (src_tick) begin
         if (cnt_ff == last) begin
            cnt_ff <= '0;
            div_ff <= div_value;
         end else begin
            cnt_ff <= cnt_ff + (DIV_W+1)'(1);
         end
      end
   end

   // ==========================================================
   // Machine cycle and peripheral phase
   always_ff @(posedge clk) begin
      if (rst || !run) begin
         phase_ff <= 1'b0;
      end else if (period_end) begin
         phase_ff <= ~phase_ff;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ticks_ff <= '0;
      end else begin
         ticks_ff.cpu <= period_end;
         ticks_ff.machine <= period_end && phase_ff;
         ticks_ff.periph <= period_end && phase_ff;
      end
   end

   assign ticks = ticks_ff;

endmodule

//--- src/ccg_clock_unit.sv
// Clock generation unit: source selection, wake-up hold, divider and clock registers.
//
// Behaviour
// - The selected source feeds a programmable divider whose output is the CPU clock.
// - One machine cycle is exactly two CPU clock cycles.
// - The peripheral clock runs at half the CPU clock rate.
// - The RC oscillator runs at 7.373 MHz, or 14.746 MHz with doubler set.
// - Six-bit RC tuning field, loaded with factory value only on power-on reset.
// - Top bit of the tuning register switches between primary source and RC.
// - Low-power bit clears on every reset; software sets it only at 8 MHz or less.
// - The divider reaches a largest division of 510.
// - A new divider value may be written anytime without disturbing execution.
// - The 400 kHz watchdog oscillator is a selectable low-power source.
// - External option clocks from the clock pin, 0 Hz up to 18 MHz.
// - A wake-up timer holds the CPU clock until the source stabilises.
// - The primary source comes from nonvolatile configuration, not a register.
// - The clock pin works as a plain port pin when not the source.
`timescale 1ns/1ps
module ccg_clock_unit #(
   parameter int WAKE_RC = ccg_pkg::WAKE_RC_EDGES,
   parameter int WAKE_WDT = ccg_pkg::WAKE_WDT_EDGES,
   parameter int WAKE_EXT = ccg_pkg::WAKE_EXT_EDGES
) (
   // Clock and resets
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic POR,
   // Nonvolatile configuration and factory calibration
   input wire ccg_pkg::ccg_ucfg_t UCFG,
   input wire logic [5:0] FACTORY_TRIM,
   // Oscillator and pin inputs
   input wire logic RC_OSC_IN,
   input wire logic WDT_OSC_IN,
   input wire logic EXT_CLK_PIN_IN,
   // Special function register port
   input wire logic [7:0] SFR_ADDR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   output logic [7:0] SFR_RDATA,
   // Clock outputs
   output ccg_pkg::ccg_ticks_t CLK_TICKS,
   output logic CPU_CLK_RUN,
   output ccg_pkg::ccg_src_t ACTIVE_SRC,
   // Oscillator controls
   output logic [5:0] RC_TRIM_OUT,
   output logic RC_DOUBLER_EN,
   output logic LOW_POWER_CLK,
   // External pin as port pin
   output logic EXT_PIN_IS_GPIO,
   output logic EXT_PIN_GPIO_IN
);

   // ==========================================================
   // Declarations
   logic any_rst;
   ccg_pkg::ccg_ucfg_t cfg_ff;
   logic [ccg_pkg::TRIM_W-1:0] trim_ff;
   logic rcsel_ff;
   logic spare_ff;
   logic [ccg_pkg::DIV_REG_W-1:0] div_reg_ff;
   logic lowpow_ff;
   logic [7:0] rdata_ff;
   logic [2:0] meta_ff;
   logic [2:0] sync_ff;
   logic [2:0] prev_ff;
   logic [2:0] rise;
   ccg_pkg::ccg_src_t sel_src;
   ccg_pkg::ccg_src_t cur_src_ff;
   ccg_pkg::ccg_state_t state_ff;
   ccg_pkg::ccg_state_t nxt_state;
   logic [ccg_pkg::WAKE_CNT_W-1:0] wake_cnt_ff;
   logic [ccg_pkg::WAKE_CNT_W-1:0] wake_target;
   logic src_tick;
   logic gpio_ff;

   assign any_rst = RST || POR;

   // ==========================================================
   // Wake-up hold length for a given source
   function automatic logic [ccg_pkg::WAKE_CNT_W-1:0] wake_len(input ccg_pkg::ccg_src_t s);
      case (s)
         ccg_pkg::SRC_WDT: wake_len = ccg_pkg::WAKE_CNT_W'(WAKE_WDT);
         ccg_pkg::SRC_EXT: wake_len = ccg_pkg::WAKE_CNT_W'(WAKE_EXT);
         default: wake_len = ccg_pkg::WAKE_CNT_W'(WAKE_RC);
      endcase
   endfunction

   // ==========================================================
   // Configuration capture
   // The primary source is caught while reset is held, so later writes by
   // software can never move it.
   always_ff @(posedge CORE_CLK) begin
      if (any_rst) begin
         cfg_ff <= UCFG;
      end
   end

   // ==========================================================
   // Source synchronisers and edge detection
   // Order: bit 0 RC oscillator, bit 1 watchdog oscillator, bit 2 pin.
   always_ff @(posedge CORE_CLK) begin
      if (any_rst) begin
         meta_ff <= '0;
         sync_ff <= '0;
         prev_ff <= '0;
      end else begin
         meta_ff <= {EXT_CLK_PIN_IN, WDT_OSC_IN, RC_OSC_IN};
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   assign rise = sync_ff & ~prev_ff;

   // ==========================================================
   // Source selection
   always_comb begin
      if (rcsel_ff) begin
         sel_src = ccg_pkg::SRC_RC;
      end else begin
         sel_src = cfg_ff.src;
      end
   end

   // Edges are taken only from the source the hold logic has settled on.
   always_comb begin
      case (cur_src_ff)
         ccg_pkg::SRC_WDT: src_tick = rise[1];
         ccg_pkg::SRC_EXT: src_tick = rise[2];
         default: src_tick = rise[0];
      endcase
   end

   // ==========================================================
   // Wake-up hold state machine
   // Any change of source stops the CPU ticks at once and restarts the hold
   // count on the new source, so no pulse of mixed origin can reach the core.
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ccg_pkg::ST_WAIT: begin
            if (src_tick && (wake_cnt_ff + 1'b1 >= wake_target)) begin
               nxt_state = ccg_pkg::ST_RUN;
            end
         end
         ccg_pkg::ST_RUN: begin
            if (sel_src != cur_src_ff) begin
               nxt_state = ccg_pkg::ST_WAIT;
            end
         end
         default: nxt_state = ccg_pkg::ST_WAIT;
      endcase
   end

   assign wake_target = wake_len(cur_src_ff);

   always_ff @(posedge CORE_CLK) begin
      if (any_rst) begin
         state_ff <= ccg_pkg::ST_WAIT;
      end else if (sel_src != cur_src_ff) begin
         state_ff <= ccg_pkg::ST_WAIT;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (any_rst) begin
         cur_src_ff <= ccg_pkg::SRC_RC;
         wake_cnt_ff <= '0;
      end else if (sel_src != cur_src_ff) begin
         cur_src_ff <= sel_src;
         wake_cnt_ff <= '0;
      end else if (state_ff == ccg_pkg::ST_WAIT && src_tick) begin
         wake_cnt_ff <= wake_cnt_ff + 1'b1;
      end
   end

   // ==========================================================
   // Register writes
   // The tuning register answers to power-on reset only.
   always_ff @(posedge CORE_CLK) begin
      if (POR) begin
         trim_ff <= FACTORY_TRIM;
         rcsel_ff <= ccg_pkg::TRIM_RCSEL_RST;
         spare_ff <= ccg_pkg::TRIM_SPARE_RST;
      end else if (SFR_WR && SFR_ADDR == ccg_pkg::ADDR_TRIM) begin
         trim_ff <= SFR_WDATA[ccg_pkg::TRIM_W-1:0];
         rcsel_ff <= SFR_WDATA[ccg_pkg::TRIM_RCSEL_BIT];
         spare_ff <= SFR_WDATA[ccg_pkg::TRIM_SPARE_BIT];
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (any_rst) begin
         div_reg_ff <= ccg_pkg::DIV_RST;
      end else if (SFR_WR && SFR_ADDR == ccg_pkg::ADDR_DIV) begin
         div_reg_ff <= SFR_WDATA;
      end
   end

   // Software is expected to set this bit only while the CPU clock is slow.
   always_ff @(posedge CORE_CLK) begin
      if (any_rst) begin
         lowpow_ff <= ccg_pkg::AUX1_LP_RST;
      end else if (SFR_WR && SFR_ADDR == ccg_pkg::ADDR_AUX1) begin
         lowpow_ff <= SFR_WDATA[ccg_pkg::AUX1_LP_BIT];
      end
   end

   // ==========================================================
   // Register reads, answered one cycle after the strobe
   always_ff @(posedge CORE_CLK) begin
      if (any_rst) begin
         rdata_ff <= 8'h00;
      end else if (SFR_RD) begin
         case (SFR_ADDR)
            ccg_pkg::ADDR_TRIM: rdata_ff <= {rcsel_ff, spare_ff, trim_ff};
            ccg_pkg::ADDR_DIV: rdata_ff <= div_reg_ff;
            ccg_pkg::ADDR_AUX1: rdata_ff <= {lowpow_ff, 7'h00};
            default: rdata_ff <= 8'h00;
         endcase
      end
   end

   // ==========================================================
   // Clock pin as port pin
   always_ff @(posedge CORE_CLK) begin
      if (any_rst) begin
         gpio_ff <= 1'b0;
      end else begin
         gpio_ff <= sync_ff[2];
      end
   end

   // ==========================================================
   // Divider
   ccg_divider #(
      .DIV_W(ccg_pkg::DIV_REG_W)
   ) u_div (
      .clk(CORE_CLK),
      .rst(any_rst),
      .src_tick(src_tick),
      .run(state_ff == ccg_pkg::ST_RUN),
      .div_value(div_reg_ff),
      .ticks(CLK_TICKS)
   );

   // ==========================================================
   // Outputs
   assign SFR_RDATA = rdata_ff;
   assign CPU_CLK_RUN = (state_ff == ccg_pkg::ST_RUN);
   assign ACTIVE_SRC = cur_src_ff;
   assign RC_TRIM_OUT = trim_ff;
   assign RC_DOUBLER_EN = cfg_ff.rc_doubler;
   assign LOW_POWER_CLK = lowpow_ff;
   assign EXT_PIN_IS_GPIO = (cur_src_ff != ccg_pkg::SRC_EXT);
   assign EXT_PIN_GPIO_IN = gpio_ff;

endmodule

//--- tb/ccg_ext_clk_model.sv
// Model of the external clock source that drives the clock pin.
`timescale 1ns/1ps
module ccg_ext_clk_model (
   // Clock
   input wire logic clk,
   // Control
   input wire logic en,
   input wire logic [7:0] half,
   // Pin
   output logic pin
);
   logic [7:0] cnt_ff;
   // ==========================================================
   // Square wave of two half periods; stopped it rests low, not at its last level.
   // The rate stays far below the 18 MHz limit, so no reset pin is needed.
   always @(posedge clk) begin
      if (!en) begin
         cnt_ff <= 8'h00;
         pin <= 1'b0;
      end else if (cnt_ff + 8'h01 >= half) begin
         cnt_ff <= 8'h00;
         pin <= ~pin;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end
endmodule

//--- tb/ccg_clock_unit_checker.sv
// Concurrent checks on the ports of the clock generation unit.
`timescale 1ns/1ps
module ccg_clock_unit_checker (
   // Clock and resets
   input wire logic CORE_CLK,
   input wire logic RST,
   input wire logic POR,
   // Inputs watched
   input wire logic [5:0] FACTORY_TRIM,
   input wire logic [7:0] SFR_ADDR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   // Outputs watched
   input wire logic [7:0] SFR_RDATA,
   input wire ccg_pkg::ccg_ticks_t CLK_TICKS,
   input wire logic CPU_CLK_RUN,
   input wire ccg_pkg::ccg_src_t ACTIVE_SRC,
   input wire logic [5:0] RC_TRIM_OUT,
   input wire logic LOW_POWER_CLK,
   input wire logic EXT_PIN_IS_GPIO
);
   logic ph_ff;
   // ==========================================================
   // Phase of the CPU tick pair; it restarts whenever the clock is held.
   always_ff @(posedge CORE_CLK) begin
      if (RST || POR || !CPU_CLK_RUN) ph_ff <= 1'b0;
      else if (CLK_TICKS.cpu) ph_ff <= ~ph_ff;
   end
   chk_wait_no_tick: assert property (@(posedge CORE_CLK) disable iff (RST || POR)
      (!CPU_CLK_RUN && !$past(CPU_CLK_RUN)) |-> !CLK_TICKS.cpu) else $error("tick while held");
   chk_machine_on_cpu: assert property (@(posedge CORE_CLK) disable iff (RST || POR)
      CLK_TICKS.machine |-> CLK_TICKS.cpu) else $error("machine tick without cpu tick");
   chk_machine_phase: assert property (@(posedge CORE_CLK) disable iff (RST || POR)
      CLK_TICKS.cpu |-> CLK_TICKS.machine == ph_ff) else $error("machine tick phase wrong");
   chk_periph_half_rate: assert property (@(posedge CORE_CLK) disable iff (RST || POR)
      CLK_TICKS.periph == CLK_TICKS.machine) else $error("peripheral tick not at half rate");
   chk_lp_reset_clear: assert property (@(posedge CORE_CLK) disable iff (POR)
      RST |=> !LOW_POWER_CLK) else $error("low power bit survives reset");
   chk_pin_gpio_free: assert property (@(posedge CORE_CLK) disable iff (RST || POR)
      EXT_PIN_IS_GPIO == (ACTIVE_SRC != ccg_pkg::SRC_EXT)) else $error("pin role wrong");
   chk_trim_hold_rst: assert property (@(posedge CORE_CLK) disable iff (POR)
      RST |=> $stable(RC_TRIM_OUT)) else $error("tuning changed by plain reset");
   chk_trim_por_load: assert property (@(posedge CORE_CLK) disable iff (RST)
      POR |=> RC_TRIM_OUT == $past(FACTORY_TRIM)) else $error("tuning not loaded at power-on");
   chk_trim_read_back: assert property (@(posedge CORE_CLK) disable iff (RST || POR)
      (SFR_RD && SFR_ADDR == ccg_pkg::ADDR_TRIM) |=> SFR_RDATA[5:0] == $past(RC_TRIM_OUT))
      else $error("tuning read back wrong");
   chk_rc_sel_src: assert property (@(posedge CORE_CLK) disable iff (RST || POR)
      (SFR_WR && SFR_ADDR == ccg_pkg::ADDR_TRIM && SFR_WDATA[7]) |-> ##[1:3]
      ACTIVE_SRC == ccg_pkg::SRC_RC) else $error("rc select ignored");
endmodule
bind ccg_clock_unit ccg_clock_unit_checker ccg_clock_unit_checker_inst (.CORE_CLK(CORE_CLK),
   .RST(RST), .POR(POR), .FACTORY_TRIM(FACTORY_TRIM), .SFR_ADDR(SFR_ADDR),
   .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
   .CLK_TICKS(CLK_TICKS), .CPU_CLK_RUN(CPU_CLK_RUN), .ACTIVE_SRC(ACTIVE_SRC),
   .RC_TRIM_OUT(RC_TRIM_OUT), .LOW_POWER_CLK(LOW_POWER_CLK), .EXT_PIN_IS_GPIO(EXT_PIN_IS_GPIO));

//--- tb/tb_top.sv
// Self-checking testbench of the clock generation unit.
`timescale 1ns/1ps
module tb_top;
   logic clk, rst, por, rc, wdt, pin, en, wr_s, rd_s, run, dbl, lp, gpio, gpin, rd_p;
   logic [5:0] ftrim, trim_o;
   logic [7:0] addr, wdata, rdata, tv;
   ccg_pkg::ccg_ucfg_t ucfg;
   ccg_pkg::ccg_ticks_t tk;
   ccg_pkg::ccg_src_t asrc;
   int error_cnt = 0, samples_checked = 0, tcnt = 0, last = 0, rcc = 0, wdc = 0;
   integer seed;
   logic [15:0] rd_q[$], per_q[$];
   logic [7:0] dv[4] = '{8'h00, 8'h01, 8'h02, 8'hff};
   ccg_clock_unit #(.WAKE_RC(4), .WAKE_WDT(4), .WAKE_EXT(4)) ccg_clock_unit_inst (
      .CORE_CLK(clk), .RST(rst), .POR(por), .UCFG(ucfg), .FACTORY_TRIM(ftrim),
      .RC_OSC_IN(rc), .WDT_OSC_IN(wdt), .EXT_CLK_PIN_IN(pin), .SFR_ADDR(addr),
      .SFR_WDATA(wdata), .SFR_WR(wr_s), .SFR_RD(rd_s), .SFR_RDATA(rdata), .CLK_TICKS(tk),
      .CPU_CLK_RUN(run), .ACTIVE_SRC(asrc), .RC_TRIM_OUT(trim_o), .RC_DOUBLER_EN(dbl),
      .LOW_POWER_CLK(lp), .EXT_PIN_IS_GPIO(gpio), .EXT_PIN_GPIO_IN(gpin));
   ccg_ext_clk_model ccg_ext_clk_model_inst (.clk(clk), .en(en), .half(8'h03), .pin(pin));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // ==========================================================
   // Oscillators: RC period 6 cycles, watchdog period 10 cycles.
   always @(posedge clk) begin
      rcc++;
      wdc++;
      if (rcc == 3) begin
         rc <= ~rc;
         rcc = 0;
      end
      if (wdc == 5) begin
         wdt <= ~wdt;
         wdc = 0;
      end
   end
   task check(input string n, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task finish_test;
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ==========================================================
   // Result watcher: read data one cycle after the strobe, tick spacing in cycles.
   always @(posedge clk) begin
      tcnt++;
      if (rd_p) check("rdata", {8'h00, rdata}, rd_q.pop_front());
      rd_p = rd_s;
      if (tk.cpu === 1'b1) begin
         if (per_q.size() > 0) check("period", tcnt - last, per_q.pop_front());
         last = tcnt;
      end
   end
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      rd_q.push_back({8'h00, exp});
      @(posedge clk);
      rd_s <= 1'b0;
   endtask
   task ticks(input int n);
      int k;
      k = 0;
      while (n > 0) begin
         @(posedge clk);
         if (tk.cpu === 1'b1) n--;
         if (++k > 20000) begin
            error_cnt++;
            finish_test();
         end
      end
   endtask
   task wait_run;
      int k;
      k = 0;
      repeat (2) @(posedge clk);
      while (run !== 1'b1) begin
         @(posedge clk);
         if (++k > 5000) begin
            error_cnt++;
            finish_test();
         end
      end
   endtask
   task per(input logic [15:0] p);
      ticks(2);
      per_q.push_back(p);
      ticks(1);
   endtask
   initial begin
      seed = 32'h96c9;
      {rc, wdt, wr_s, rd_s, rd_p, addr, wdata} = '0;
      rst <= 1'b1;
      por <= 1'b1;
      en <= 1'b0;
      ucfg <= '{1'b1, ccg_pkg::SRC_EXT};
      ftrim <= 6'($random(seed));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      por <= 1'b0;
      // The source model starts from a known low level only once it has been held off.
      en <= 1'b1;
      wait_run();
      check("doubler", dbl, 1);
      check("source", asrc, ccg_pkg::SRC_EXT);
      check("gpio", gpio, 0);
      ticks(1);
      check("pin level", gpin, 1);
      rd(ccg_pkg::ADDR_TRIM, {2'b00, ftrim});
      foreach (dv[i]) begin
         wr(ccg_pkg::ADDR_DIV, dv[i]);
         per(dv[i] == 8'h00 ? 16'd6 : 16'd12 * dv[i]);
      end
      tv = 8'($random(seed)) & 8'h7f;
      wr(ccg_pkg::ADDR_TRIM, tv);
      rd(ccg_pkg::ADDR_TRIM, tv);
      wr(ccg_pkg::ADDR_AUX1, 8'hff);
      rd(ccg_pkg::ADDR_AUX1, 8'h80);
      rd(8'h00, 8'h00);
      check("low power", lp, 1);
      wr(ccg_pkg::ADDR_DIV, 8'h05);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      check("low power", lp, 0);
      rd(ccg_pkg::ADDR_TRIM, tv);
      rd(ccg_pkg::ADDR_DIV, 8'h00);
      wait_run();
      wr(ccg_pkg::ADDR_TRIM, tv | 8'h80);
      wait_run();
      check("source", asrc, ccg_pkg::SRC_RC);
      check("gpio", gpio, 1);
      en <= 1'b0;
      per(16'd6);
      check("pin level", gpin, 0);
      ucfg <= '{1'b0, ccg_pkg::SRC_WDT};
      ftrim <= 6'($random(seed));
      por <= 1'b1;
      repeat (2) @(posedge clk);
      por <= 1'b0;
      wait_run();
      check("doubler", dbl, 0);
      check("source", asrc, ccg_pkg::SRC_WDT);
      rd(ccg_pkg::ADDR_TRIM, {2'b00, ftrim});
      per(16'd10);
      repeat (4) @(posedge clk);
      finish_test();
   end
endmodule
